// file: hcsb_core.sv
// Control bit interpreter and status word generator of the heater controller.
//
// Functional notes
// - Reset request clears fault after it falls.
// - Reset request blocks calibration and heat.
// - During reset only groups five, seven count.
// - Reset: power off, no impulses, value frozen.
// - Running calibration finishes despite reset request.
// - Half-second initialization after reset before heating.
// - Pause: no impulses, groups five/seven, hold value.
// - Pause release resumes everything without initialization.
// - Pause only in measuring; others take priority.
// - Pause never clears an active fault.
// - Set point clamped to 300 or 500.
// - Calibration running flag follows calibration state.
// - Calibration blocked while heating or cooling.
// - Fault flag holds until fault is reset.
// - Warning fault keeps fault relay inactive.
// - Near flag above 95%, cleared by stop/fault.
// - Band flag: zero when off, window follows.
// - Latch mode band flag sets once per heat cycle, clears out of band.
// - Regulating flag shows accepted heat command.
// - Actual word signed, zero in calibration/fault.
// - Fault code in low ten bits.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
module hcsb_core #(
   parameter int MS_CYCLES = hcsb_pkg::CYC_PER_MS,
   parameter logic [9:0] KB_ERR_CODE = 10'h3ff
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [hcsb_pkg::ADDR_W-1:0] busAddr,
   input wire logic [hcsb_pkg::DATA_W-1:0] busWrData,
   input wire logic busWr,
   input wire logic busRd,
   output logic [hcsb_pkg::DATA_W-1:0] busRdData,
   input wire logic measValid,
   input wire logic signed [15:0] measTemp,
   input wire logic calDone,
   input wire logic heaterCooling,
   input wire logic faultEvt,
   input wire logic [hcsb_pkg::GRP_W-1:0] faultGrp,
   input wire logic [hcsb_pkg::CODE_W-1:0] faultCode,
   input wire logic faultWarn,
   input wire logic contactorPin,
   output logic powerOn,
   output logic impulseOn,
   output logic faultRelay,
   output logic calRun
);
   import hcsb_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      hcsb_state_t st;
      logic [SET_W-1:0] setRaw;
      logic [3:0] ctrl;
      logic rangeHi;
      hcsb_band_t band;
      logic kbUsed;
      logic [LIM_W-1:0] lowLim;
      logic [LIM_W-1:0] upLim;
      logic signed [15:0] act;
      logic fault;
      logic warn;
      logic [CODE_W-1:0] code;
      logic near;
      logic inBand;
      logic bandSeen;
      logic heatPrev;
      logic [9:0] msCnt;
      logic kbWait;
      logic [1:0] kbSync;
      logic [DATA_W-1:0] rdData;
   } hcsb_regs_t;

   hcsb_regs_t q;
   hcsb_regs_t d;

   logic msTick;
   logic calReq;
   logic heatReq;
   logic rstReq;
   logic pauseReq;
   logic pauseEff;
   logic calBlk;
   logic faultOk;
   logic kbLate;
   logic nearHit;
   logic bandNow;
   logic heatRise;
   logic [SET_W-1:0] limVal;
   logic [SET_W-1:0] setLim;
   logic [DATA_W-1:0] actWord;
   logic [DATA_W-1:0] statWord;
   logic [DATA_W-1:0] errWord;
   logic [LIM_W-1:0] wrLow;
   logic [LIM_W-1:0] wrUp;

   hcsb_ms_tick #(
      .DIV(MS_CYCLES)
   ) u_tick (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .tick(msTick)
   );

   // ****************************************************************
   // Decoded control bits
   // ****************************************************************
   assign calReq = q.ctrl[B_CAL];
   assign heatReq = q.ctrl[B_HEAT];
   assign rstReq = q.ctrl[B_RST];
   assign pauseReq = q.ctrl[B_PAUSE];

   // Oversized set points are cut back rather than refused.
   assign limVal = q.rangeHi ? LIM_HI : LIM_LO;
   assign setLim = (q.setRaw > limVal) ? limVal : q.setRaw;

   // Pause is honoured only while plainly measuring.
   assign pauseEff = pauseReq && (q.st == S_MEAS) && !rstReq && !heatReq && !calReq;

   assign calBlk = heatReq || (q.st == S_HEAT) || heaterCooling;

   // Reset and pause narrow diagnosis to the wiring groups.
   assign faultOk = faultEvt && (!(rstReq || pauseEff) || (faultGrp == GRP_A) || (faultGrp == GRP_B));

   // The far end must close the loop contactor in time; lateness is a fault.
   assign kbLate = (q.st == S_INIT) && msTick && q.kbWait && (q.msCnt == KB_CNT - 10'h001);

   assign impulseOn = calRun || ((q.st != S_RST) && !rstReq && !pauseEff);
   assign powerOn = (q.st == S_HEAT) && !rstReq;
   assign faultRelay = q.fault && !q.warn;
   assign calRun = (q.st == S_CAL);

   // Integer compare keeps the sign of a below-zero reading intact.
   assign nearHit = (int'(q.act) * NEAR_DEN) > (int'(setLim) * NEAR_NUM);
   assign bandNow = (int'(q.act) >= int'(setLim) - int'(q.lowLim)) &&
                    (int'(q.act) <= int'(setLim) + int'(q.upLim));
   assign heatRise = heatReq && !q.heatPrev;

   // ****************************************************************
   // Output words
   // ****************************************************************
   assign actWord = (calRun || q.fault) ? '0 : q.act;
   assign errWord = q.fault ? {{(DATA_W - CODE_W){1'b0}}, q.code} : '0;

   always_comb begin
      statWord = '0;
      statWord[F_CALRUN] = calRun;
      statWord[F_CALBLK] = calBlk;
      statWord[F_FAULT] = q.fault;
      statWord[F_WARN] = q.warn && q.fault;
      statWord[F_NEAR] = q.near;
      statWord[F_BAND] = q.inBand;
      statWord[F_REG] = (q.st == S_HEAT);
   end

   // Band limits above the documented maximum are held at the maximum.
   assign wrLow = (busWrData[LIM_W-1:0] > BAND_MAX) ? BAND_MAX : busWrData[LIM_W-1:0];
   assign wrUp = (busWrData[BAND_UP +: LIM_W] > BAND_MAX) ? BAND_MAX : busWrData[BAND_UP +: LIM_W];

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      d = q;
      d.kbSync = {q.kbSync[0], contactorPin};
      d.heatPrev = heatReq;

      if (busWr) begin
         if (busAddr == A_SET) begin
            d.setRaw = busWrData[SET_W-1:0];
         end else if (busAddr == A_CTRL) begin
            d.ctrl = busWrData[3:0];
         end else if (busAddr == A_CFG) begin
            d.rangeHi = busWrData[CFG_RANGE];
            d.band = hcsb_band_t'(busWrData[CFG_BAND +: 2]);
            d.kbUsed = busWrData[CFG_KB];
         end else if (busAddr == A_BAND) begin
            d.lowLim = wrLow;
            d.upLim = wrUp;
         end
      end

      d.rdData = '0;
      if (busRd) begin
         if (busAddr == A_SET) begin
            d.rdData = {{(DATA_W - SET_W){1'b0}}, q.setRaw};
         end else if (busAddr == A_CTRL) begin
            d.rdData = {12'h000, q.ctrl};
         end else if (busAddr == A_CFG) begin
            d.rdData = {12'h000, q.kbUsed, q.band, q.rangeHi};
         end else if (busAddr == A_BAND) begin
            d.rdData = {1'b0, q.upLim, 1'b0, q.lowLim};
         end else if (busAddr == A_ACT) begin
            d.rdData = actWord;
         end else if (busAddr == A_STAT) begin
            d.rdData = statWord;
         end else if (busAddr == A_ERR) begin
            d.rdData = errWord;
         end
      end

      // The held value is the last valid one before the pause.
      if (measValid && impulseOn) begin
         d.act = measTemp;
      end

      if (q.kbSync[1]) begin
         d.kbWait = 1'b0;
      end

      case (q.st)
         S_MEAS: begin
            if (rstReq) begin
               d.st = S_RST;
            end else if (calReq && !calBlk && !q.fault) begin
               d.st = S_CAL;
            end else if (heatReq && !q.fault && (setLim >= MIN_SET)) begin
               d.st = S_HEAT;
            end
         end
         S_CAL: begin
            // A reset request raised mid-run waits for the run's end.
            if (calDone) begin
               d.st = rstReq ? S_RST : S_MEAS;
            end
         end
         S_HEAT: begin
            if (rstReq) begin
               d.st = S_RST;
            end else if (!heatReq || q.fault) begin
               d.st = S_MEAS;
            end
         end
         S_RST: begin
            // The request acts on its falling edge only.
            if (!rstReq) begin
               d.st = S_INIT;
               d.msCnt = '0;
               d.kbWait = q.kbUsed;
               d.fault = 1'b0;
               d.warn = 1'b0;
               d.code = '0;
            end
         end
         S_INIT: begin
            if (rstReq) begin
               d.st = S_RST;
            end else if (q.msCnt == INIT_CNT) begin
               d.st = S_MEAS;
            end else if (msTick) begin
               d.msCnt = q.msCnt + 10'h001;
            end
         end
         default: begin
            d.st = S_MEAS;
         end
      endcase

      // Set after clear: an event in the clearing cycle survives.
      if (faultOk) begin
         d.fault = 1'b1;
         d.warn = faultWarn;
         d.code = faultCode;
      end else if (kbLate) begin
         d.fault = 1'b1;
         d.warn = 1'b0;
         d.code = KB_ERR_CODE;
      end

      if (!heatReq || q.fault) begin
         d.near = 1'b0;
      end else if ((q.st == S_HEAT) && nearHit) begin
         d.near = 1'b1;
      end

      if (q.band == BM_WIN) begin
         d.inBand = bandNow;
      end else if (q.band == BM_LATCH) begin
         if (heatRise) begin
            d.inBand = 1'b0;
            d.bandSeen = 1'b0;
         end else if (heatReq) begin
            if (bandNow && !q.bandSeen) begin
               d.inBand = 1'b1;
               d.bandSeen = 1'b1;
            end else if (!bandNow) begin
               d.inBand = 1'b0;
            end
         end
      end else begin
         d.inBand = 1'b0;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.st <= S_MEAS;
         q.band <= BM_WIN;
      end else begin
         q <= d;
      end
   end

   assign busRdData = q.rdData;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   chk_rst_power: assert property (
      rstReq |-> (!powerOn && !impulseOn) || calRun)
      else $error("power or impulses active during reset request");

   chk_rst_block: assert property (
      (rstReq && (q.st != S_CAL)) |=> (q.st == S_RST))
      else $error("heat or calibration accepted under reset request");

   chk_cal_keep: assert property (
      (calRun && !calDone) |=> calRun)
      else $error("calibration aborted before its end");

   chk_init_noheat: assert property (
      (q.st == S_INIT) |=> (q.st != S_HEAT))
      else $error("heating started during initialization");

   chk_pause_hold: assert property (
      pauseEff |=> (q.act == $past(q.act)))
      else $error("actual value changed during pause");

   chk_relay_warn: assert property (
      (q.fault && q.warn) |-> !faultRelay)
      else $error("fault relay active for a warning");

   chk_near_clear: assert property (
      (!heatReq || q.fault) |=> !q.near)
      else $error("near flag not cleared");

   chk_band_off: assert property (
      (q.band == BM_OFF) ##1 (q.band == BM_OFF) |-> !q.inBand)
      else $error("band flag set in off mode");

   chk_fault_hold: assert property (
      (q.fault && !((q.st == S_RST) && !rstReq)) |=> q.fault)
      else $error("fault flag dropped without reset");

   chk_act_zero: assert property (
      (busRd && (busAddr == A_ACT) && (calRun || q.fault)) |=> (busRdData == '0))
      else $error("actual word not zero in calibration or fault");

   chk_err_code: assert property (
      (busRd && (busAddr == A_ERR) && q.fault && !faultOk) |=> (busRdData[CODE_W-1:0] == $past(q.code)))
      else $error("error code word wrong");

   chk_clamp: assert property (
      (q.setRaw > limVal) |-> (setLim == (q.rangeHi ? LIM_HI : LIM_LO)) ##1 (setLim <= LIM_HI))
      else $error("set point not clamped");

endmodule // hcsb_core

// file: hcsb_far_model.sv
// Behavioural far side of the heater block: temperature sensing source and loop contactor.
`timescale 1ns/100ps
module hcsb_far_model (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic impulseOn,
   input wire logic signed [15:0] tempNow,
   input wire logic rstHeld,
   input wire logic [31:0] kbDelay,
   output logic measValid,
   output logic signed [15:0] measTemp,
   output logic contactorPin
);
   logic [1:0] phase;
   logic [31:0] kbCnt;

   // A sample returns every fourth cycle, and only while impulses are sent.
   // Between samples the data lines show the inverse, so a stale value never passes.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         phase <= 2'h0;
         measValid <= 1'b0;
         measTemp <= 16'sh0000;
      end else begin
         phase <= phase + 2'h1;
         measValid <= impulseOn && (phase == 2'h3);
         measTemp <= (impulseOn && (phase == 2'h3)) ? tempNow : ~tempNow;
      end
   end

   // The contactor drops while reset is requested and closes again after kbDelay cycles.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         kbCnt <= 32'h0;
         contactorPin <= 1'b1;
      end else if (rstHeld) begin
         kbCnt <= 32'h0;
         contactorPin <= 1'b0;
      end else if (kbCnt < kbDelay) begin
         kbCnt <= kbCnt + 32'h1;
      end else begin
         contactorPin <= 1'b1;
      end
   end
endmodule // hcsb_far_model

// file: hcsb_ms_tick.sv
// Divider that gives a one-cycle enable pulse once every millisecond.
`timescale 1ns/100ps
module hcsb_ms_tick #(
   parameter int DIV = hcsb_pkg::CYC_PER_MS
) (
   input wire logic ref_clk,
   input wire logic nrst,
   output logic tick
);
   import hcsb_pkg::*;

   localparam int CW = $clog2(DIV);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } hcsb_div_t;

   hcsb_div_t q;
   hcsb_div_t d;

   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (q.cnt == CW'(DIV - 1)) begin
         d.cnt = '0;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + CW'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;

endmodule // hcsb_ms_tick

// file: hcsb_pkg.sv
// Constants, register map and types of the heater control and status block.
package hcsb_pkg;

   // ****************************************************************
   // Register bus
   // ****************************************************************
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam logic [4:0] A_SET = 5'h00;
   localparam logic [4:0] A_CTRL = 5'h04;
   localparam logic [4:0] A_CFG = 5'h08;
   localparam logic [4:0] A_BAND = 5'h0c;
   localparam logic [4:0] A_ACT = 5'h10;
   localparam logic [4:0] A_STAT = 5'h14;
   localparam logic [4:0] A_ERR = 5'h18;

   // ****************************************************************
   // Field layouts
   // ****************************************************************
   localparam int SET_W = 9;
   localparam int CODE_W = 10;
   localparam int GRP_W = 4;
   localparam int LIM_W = 7;
   localparam int B_CAL = 0;
   localparam int B_HEAT = 1;
   localparam int B_RST = 2;
   localparam int B_PAUSE = 3;
   localparam int CFG_RANGE = 0;
   localparam int CFG_BAND = 1;
   localparam int CFG_KB = 3;
   localparam int BAND_UP = 8;
   localparam int F_CALRUN = 0;
   localparam int F_CALBLK = 1;
   localparam int F_FAULT = 2;
   localparam int F_WARN = 3;
   localparam int F_NEAR = 4;
   localparam int F_BAND = 5;
   localparam int F_REG = 6;

   // ****************************************************************
   // Limits and error groups
   // ****************************************************************
   localparam logic [8:0] LIM_LO = 9'h12c;
   localparam logic [8:0] LIM_HI = 9'h1f4;
   localparam logic [8:0] MIN_SET = 9'h028;
   localparam logic [6:0] BAND_MAX = 7'h63;
   localparam int NEAR_NUM = 32'h13;
   localparam int NEAR_DEN = 32'h14;
   localparam logic [3:0] GRP_A = 4'h5;
   localparam logic [3:0] GRP_B = 4'h7;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_HZ = 125_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
   localparam int INIT_MS = 500;
   localparam int KB_MS = 50;
   localparam logic [9:0] INIT_CNT = 10'(INIT_MS);
   localparam logic [9:0] KB_CNT = 10'(KB_MS);

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      BM_OFF = 2'h0,
      BM_WIN = 2'h1,
      BM_LATCH = 2'h2
   } hcsb_band_t;

   typedef enum logic [4:0] {
      S_MEAS = 5'h01,
      S_CAL = 5'h02,
      S_RST = 5'h04,
      S_INIT = 5'h08,
      S_HEAT = 5'h10
   } hcsb_state_t;

endpackage

// file: test_heater_control_status_bits.sv
// Self-checking random bench of the heater control and status block.
`timescale 1ns/100ps
module test_heater_control_status_bits;
   import hcsb_pkg::*;
   // One millisecond is shortened to ten cycles; the code value is arbitrary.
   localparam int MSC = 10;
   localparam logic [9:0] KB_CODE = 10'h2a5;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [ADDR_W-1:0] busAddr = 5'h00;
   logic [DATA_W-1:0] busWrData = 16'h0000;
   logic busWr = 1'b0;
   logic busRd = 1'b0;
   logic [DATA_W-1:0] busRdData;
   logic measValid, contactorPin, powerOn, impulseOn, faultRelay, calRun;
   logic signed [15:0] measTemp;
   logic calDone = 1'b0;
   logic heaterCooling = 1'b0;
   logic faultEvt = 1'b0;
   logic [GRP_W-1:0] faultGrp = 4'h0;
   logic [CODE_W-1:0] faultCode = 10'h000;
   logic faultWarn = 1'b0;
   logic signed [15:0] tempNow = 16'sh0000;
   logic rstHeld = 1'b0;
   logic [31:0] kbDelay = 32'h0;
   int n_mismatch = 0;
   int compares = 0;
   int s, t, tA, tB;
   logic [15:0] w;
   logic [9:0] code;
   int lh[6] = '{1, 1, 1, 0, 1, 0};
   int lt[6] = '{200, 250, 200, 200, 200, 250};
   logic le[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

   always #4 ref_clk = ~ref_clk;

   hcsb_core #(.MS_CYCLES(MSC), .KB_ERR_CODE(KB_CODE)) i_dut (
      .ref_clk(ref_clk), .nrst(nrst), .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr),
      .busRd(busRd), .busRdData(busRdData), .measValid(measValid), .measTemp(measTemp),
      .calDone(calDone), .heaterCooling(heaterCooling), .faultEvt(faultEvt), .faultGrp(faultGrp),
      .faultCode(faultCode), .faultWarn(faultWarn), .contactorPin(contactorPin), .powerOn(powerOn),
      .impulseOn(impulseOn), .faultRelay(faultRelay), .calRun(calRun));

   hcsb_far_model i_far (
      .ref_clk(ref_clk), .nrst(nrst), .impulseOn(impulseOn), .tempNow(tempNow), .rstHeld(rstHeld),
      .kbDelay(kbDelay), .measValid(measValid), .measTemp(measTemp), .contactorPin(contactorPin));

   // ****************************************************************
   // Bus cycles, stimulus and comparisons
   // ****************************************************************
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      busWr <= 1'b1;
      busAddr <= a;
      busWrData <= d;
      @(posedge ref_clk);
      busWr <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      busRd <= 1'b1;
      busAddr <= a;
      @(posedge ref_clk);
      busRd <= 1'b0;
      #1 d = busRdData;
   endtask

   task automatic wait_ms(input int n);
      repeat (n * MSC) @(posedge ref_clk);
      #1;
   endtask

   task automatic fault(input logic [3:0] g, input logic [9:0] c, input logic wrn);
      @(posedge ref_clk);
      faultEvt <= 1'b1;
      faultGrp <= g;
      faultCode <= c;
      faultWarn <= wrn;
      @(posedge ref_clk);
      faultEvt <= 1'b0;
      faultWarn <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chkb(input logic got, input logic exp, input string what);
      chk({15'h0, got}, {15'h0, exp}, what);
   endtask

   function automatic logic nearExp(input int sp, input int tv);
      return (tv * NEAR_DEN) > (sp * NEAR_NUM);
   endfunction

   function automatic logic inBand(input int sp, input int big, input int tv);
      int c;
      c = (big != 0) ? ((sp > LIM_HI) ? LIM_HI : sp) : ((sp > LIM_LO) ? LIM_LO : sp);
      return (tv >= c - 5) && (tv <= c + 5);
   endfunction

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Reset request with the contactor closing kbMs after release; a fault must be pending.
   task automatic doReset(input int kbMs);
      kbDelay <= 32'(kbMs * MSC);
      wr(A_CTRL, 16'h0006);
      rstHeld <= 1'b1;
      wait_ms(1);
      chkb(powerOn, 1'b0, "power in reset");
      chkb(impulseOn, 1'b0, "impulses in reset");
      rd(A_STAT, w);
      chkb(w[F_REG], 1'b0, "heat taken in reset");
      chkb(w[F_FAULT], 1'b1, "fault cleared while held");
      wr(A_CTRL, 16'h0002);
      rstHeld <= 1'b0;
      rd(A_STAT, w);
      chkb(w[F_FAULT], 1'b0, "fault kept after release");
      wait_ms(40);
      rd(A_STAT, w);
      chkb(w[F_REG], 1'b0, "heat during init");
      wait_ms(15);
      rd(A_STAT, w);
      chkb(w[F_FAULT], 1'(kbMs > KB_MS), "contactor check");
      rd(A_ERR, w);
      if (kbMs > KB_MS) chk(w, {6'h00, KB_CODE}, "contactor code");
      wait_ms(460);
      rd(A_STAT, w);
      chkb(w[F_REG], 1'(kbMs <= KB_MS), "heat after init");
      $display("Test reset with contactor %0d ms done", kbMs);
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      void'($urandom(5645));
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      rd(A_STAT, w);
      chk(w & 16'h0045, 16'h0000, "status after reset");
      rd(5'h1c, w);
      chk(w, 16'h0000, "unmapped read");
      $display("Test reset values done");

      wr(A_CFG, 16'h000a);
      tA = $urandom_range(500) - 100;
      tB = $urandom_range(500) - 100;
      tempNow <= 16'(tA);
      wait_ms(2);
      wr(A_CTRL, 16'h0008);
      tempNow <= 16'(tB);
      chkb(impulseOn, 1'b0, "impulses in pause");
      wait_ms(2);
      rd(A_ACT, w);
      chk(w, 16'(tA), "actual held in pause");
      code = 10'($urandom_range(1023));
      fault(4'h3, code, 1'b0);
      rd(A_STAT, w);
      chkb(w[F_FAULT], 1'b0, "other group in pause");
      wr(A_CTRL, 16'h0000);
      chkb(impulseOn, 1'b1, "impulses after pause");
      wait_ms(2);
      rd(A_ACT, w);
      chk(w, 16'(tB), "actual after pause");
      wr(A_CTRL, 16'h0008);
      fault(GRP_B, code, 1'b0);
      wr(A_CTRL, 16'h0000);
      wr(A_CTRL, 16'h0008);
      rd(A_STAT, w);
      chkb(w[F_FAULT], 1'b1, "fault in pause");
      wr(A_CTRL, 16'h0000);
      chkb(faultRelay, 1'b1, "relay on fault");
      rd(A_ERR, w);
      chk(w, {6'h00, code}, "error code");
      rd(A_ACT, w);
      chk(w, 16'h0000, "actual on fault");
      $display("Test pause done");

      wr(A_SET, 16'd200);
      doReset(60);
      doReset(20);
      chkb(powerOn, 1'b1, "power in heat");
      rd(A_STAT, w);
      chkb(w[F_CALBLK], 1'b1, "calibration blocked in heat");
      wr(A_CTRL, 16'h000a);
      chkb(impulseOn, 1'b1, "pause ignored in heat");
      wr(A_CFG, 16'h000b);
      for (int i = 0; i < 6; i++) begin
         s = 40 + $urandom_range(260);
         t = (s * NEAR_NUM) / NEAR_DEN + $urandom_range(2) - 1;
         if (i < 2) begin
            s = 200;
            t = 190 + i;
         end
         wr(A_CTRL, 16'h0000);
         wr(A_SET, 16'(s));
         tempNow <= 16'(t);
         wait_ms(2);
         wr(A_CTRL, 16'h0002);
         wait_ms(2);
         rd(A_STAT, w);
         chkb(w[F_NEAR], nearExp(s, t), "near flag");
      end
      tempNow <= 16'(s);
      wait_ms(2);
      wr(A_CTRL, 16'h0000);
      rd(A_STAT, w);
      chkb(w[F_NEAR], 1'b0, "near after heat off");
      $display("Test heat done");

      wr(A_CFG, 16'h000d);
      wr(A_BAND, 16'h0505);
      wr(A_SET, 16'd200);
      for (int i = 0; i < 6; i++) begin
         wr(A_CTRL, 16'(lh[i] * 2));
         tempNow <= 16'(lt[i]);
         wait_ms(2);
         rd(A_STAT, w);
         chkb(w[F_BAND], le[i], "latch band flag");
      end
      wr(A_CFG, 16'h0009);
      rd(A_STAT, w);
      chkb(w[F_BAND], 1'b0, "band flag off mode");
      wr(A_SET, 16'h01ff);
      for (int i = 0; i < 3; i++) begin
         wr(A_CFG, (i == 2) ? 16'h000b : 16'h000a);
         t = (i == 0) ? 300 : ((i == 1) ? 320 : 500);
         tempNow <= 16'(t);
         wait_ms(2);
         rd(A_STAT, w);
         chkb(w[F_BAND], inBand(511, i / 2, t), "clamped window");
      end
      $display("Test band done");

      wr(A_CFG, 16'h0003);
      heaterCooling <= 1'b1;
      wr(A_CTRL, 16'h0001);
      rd(A_STAT, w);
      chk(w & 16'h0003, 16'h0002, "blocked by cooling");
      wr(A_CTRL, 16'h0000);
      heaterCooling <= 1'b0;
      wr(A_CTRL, 16'h0001);
      chkb(calRun, 1'b1, "calibration running");
      rd(A_ACT, w);
      chk(w, 16'h0000, "actual in calibration");
      kbDelay <= 32'(60 * MSC);
      rstHeld <= 1'b1;
      wr(A_CTRL, 16'h0005);
      chkb(calRun, 1'b1, "calibration kept in reset");
      calDone <= 1'b1;
      @(posedge ref_clk);
      calDone <= 1'b0;
      wait_ms(1);
      chkb(calRun, 1'b0, "calibration finished");
      wr(A_CTRL, 16'h0000);
      rstHeld <= 1'b0;
      wait_ms(510);
      rd(A_STAT, w);
      chkb(w[F_FAULT], 1'b0, "unused contactor ignored");
      fault(4'h3, code, 1'b1);
      rd(A_STAT, w);
      chk(w & 16'h000c, 16'h000c, "warning fault");
      chkb(faultRelay, 1'b0, "relay on warning");
      $display("Test calibration and warning done");
      complete_run();
   end

   // ****************************************************************
   // Watchdog
   // ****************************************************************
   initial begin
      repeat (40000) @(posedge ref_clk);
      n_mismatch++;
      $display("BAD %0t watchdog expired", $time);
      complete_run();
   end
endmodule // test_heater_control_status_bits
